// ### src/cdg_pkg.sv
// Constants, types and helpers for the CPU doze cycle gating block
package cdg_pkg;

  // Quarter phases per instruction cycle
  localparam int QPH_W = 4;
  // Phase one-hot value after reset (first quarter)
  localparam logic [QPH_W-1:0] QPH_RST = 4'h1;
  // Width of the ratio select field
  localparam int RATIO_W = 3;
  // Width of the idle-cycle counter, holds up to 255
  localparam int IDLE_W = 8;
  // Idle counter value after reset
  localparam logic [IDLE_W-1:0] IDLE_RST = 8'h00;
  // Ratio code for one active cycle in every four
  localparam logic [RATIO_W-1:0] RATIO_1_4 = 3'h1;
  // Ratio code for one active cycle in every 32
  localparam logic [RATIO_W-1:0] RATIO_1_32 = 3'h4;
  // Oscillator run request, constant in doze
  localparam logic OSC_RUN = 1'b1;
  // Reset value of the helper ratio capture
  localparam logic [RATIO_W-1:0] RATIO_RST = 3'h0;

  // Instruction cycle state of the CPU
  typedef enum logic {
    CDG_ACTIVE,
    CDG_IDLE
  } cdg_cyc_t;

  // Idle cycles that follow one active cycle: 2^(code+1)-1
  function automatic logic [IDLE_W-1:0] cdg_idle_of(
    input logic [RATIO_W-1:0] code
  );
    logic [IDLE_W:0] span;
    span = 9'h002 << code;
    return IDLE_W'(span - 9'h001);
  endfunction : cdg_idle_of

endpackage : cdg_pkg

// ### src/cdg_qphase.sv
// Free-running quarter-phase generator for the instruction cycle
`timescale 1ns/100ps
`default_nettype none
module cdg_qphase (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  output logic [cdg_pkg::QPH_W-1:0] phase_o,
  output logic last_o
);

  logic [cdg_pkg::QPH_W-1:0] phase_q;
  logic last_q;

  // Rotate the one-hot phase on every system clock
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_q <= cdg_pkg::QPH_RST;
    end else begin
      phase_q <= {phase_q[cdg_pkg::QPH_W-2:0], phase_q[cdg_pkg::QPH_W-1]};
    end
  end

  // High while the fourth quarter is showing
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_q <= 1'b0;
    end else begin
      last_q <= phase_q[cdg_pkg::QPH_W-2];
    end
  end

  assign phase_o = phase_q;
  assign last_o = last_q;

endmodule : cdg_qphase
`default_nettype wire

// ### src/cdg_doze_gate.sv
// Doze gating of CPU and program flash instruction cycles
`timescale 1ns/100ps
`default_nettype none
module cdg_doze_gate (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic slow_exec_enable_i,
  input wire logic [cdg_pkg::RATIO_W-1:0] doze_ratio_i,
  output logic [cdg_pkg::QPH_W-1:0] periph_phase_o,
  output logic [cdg_pkg::QPH_W-1:0] cpu_phase_o,
  output logic cpu_exec_o,
  output logic program_flash_fetch_o,
  output logic osc_run_o
);

  logic rst_meta_q;
  logic rst_n_q;
  logic [cdg_pkg::QPH_W-1:0] phase;
  logic phase_last;
  cdg_pkg::cdg_cyc_t cyc_q;
  cdg_pkg::cdg_cyc_t cyc_d;
  logic [cdg_pkg::IDLE_W-1:0] idle_q;
  logic [cdg_pkg::IDLE_W-1:0] idle_d;
  logic active;
  logic active_next;

  // Reset release through two flops
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // Quarter-phase source, never gated by doze
  cdg_qphase u_qphase (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_q),
    .phase_o(phase),
    .last_o(phase_last)
  );

  assign active = (cyc_q == cdg_pkg::CDG_ACTIVE);
  assign active_next = (cyc_d == cdg_pkg::CDG_ACTIVE);

  // Decide the next instruction cycle at the end of the fourth quarter
  always_comb begin
    cyc_d = cyc_q;
    idle_d = idle_q;
    if (phase_last) begin
      if (!slow_exec_enable_i || idle_q == '0) begin
        cyc_d = cdg_pkg::CDG_ACTIVE;
        idle_d = cdg_pkg::cdg_idle_of(doze_ratio_i);
      end else begin
        cyc_d = cdg_pkg::CDG_IDLE;
        idle_d = idle_q - 8'h01;
      end
    end
  end

  // Cycle state
  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cyc_q <= cdg_pkg::CDG_ACTIVE;
    end else begin
      cyc_q <= cyc_d;
    end
  end

  // Remaining idle cycles after the current one
  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      idle_q <= cdg_pkg::IDLE_RST;
    end else begin
      idle_q <= idle_d;
    end
  end

  // Peripheral phases follow the generator in every cycle
  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      periph_phase_o <= '0;
    end else begin
      periph_phase_o <= phase;
    end
  end

  // CPU phases only run in active cycles
  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cpu_phase_o <= '0;
    end else begin
      cpu_phase_o <= active ? phase : '0;
    end
  end

  // Execute flag, aligned with the CPU phases
  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cpu_exec_o <= 1'b0;
    end else begin
      cpu_exec_o <= active;
    end
  end

  // Flash fetch of the next word rides the active cycle
  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      program_flash_fetch_o <= 1'b0;
    end else begin
      program_flash_fetch_o <= active;
    end
  end

  // Oscillators are never stopped here, unlike sleep
  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      osc_run_o <= cdg_pkg::OSC_RUN;
    end else begin
      osc_run_o <= cdg_pkg::OSC_RUN;
    end
  end

  // Checking helpers: idle run length and ratio in force
  logic [cdg_pkg::IDLE_W-1:0] gap_q;
  logic [cdg_pkg::RATIO_W-1:0] cap_q;

  // Count completed idle cycles since the last active one
  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      gap_q <= cdg_pkg::IDLE_RST;
    end else if (phase_last) begin
      if (active) begin
        gap_q <= cdg_pkg::IDLE_RST;
      end else begin
        gap_q <= gap_q + 8'h01;
      end
    end
  end

  // Ratio sampled on entry to an active cycle
  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cap_q <= cdg_pkg::RATIO_RST;
    end else if (phase_last && active_next) begin
      cap_q <= doze_ratio_i;
    end
  end

  // Idle run ends when the captured ratio is used up
  AST_IDLE_END: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_q)
    (phase_last && !active && slow_exec_enable_i &&
     gap_q == cdg_pkg::cdg_idle_of(cap_q) - 8'h01) |=> active
  ) else $error("idle run did not end at ratio count");

  // Idle run continues while the ratio is not used up
  AST_IDLE_KEEP: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_q)
    (phase_last && !active && slow_exec_enable_i &&
     gap_q < cdg_pkg::cdg_idle_of(cap_q) - 8'h01) |=> !active
  ) else $error("idle run ended early");

  // One in 32: active after the 31st idle cycle
  AST_RATIO_32: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_q)
    (phase_last && !active && slow_exec_enable_i &&
     cap_q == cdg_pkg::RATIO_1_32 && gap_q == 8'h1e) |=> active
  ) else $error("ratio 1:32 did not resume after 31 idle cycles");

  // At 1:32, an active cycle is followed by idle
  AST_IDLE_31: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_q)
    (phase_last && active && slow_exec_enable_i &&
     cap_q == cdg_pkg::RATIO_1_32) |=> (!active && gap_q == 8'h00)
  ) else $error("ratio 1:32 active cycle not followed by idle");

  // One in four: active after the third idle cycle
  AST_RATIO_4: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_q)
    (phase_last && !active && slow_exec_enable_i &&
     cap_q == cdg_pkg::RATIO_1_4 && gap_q == 8'h02) |=> active
  ) else $error("ratio 1:4 did not resume after 3 idle cycles");

  // Peripheral phases stay one-hot and rotate every clock
  AST_PERIPH_ROT: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_q)
    ($onehot(periph_phase_o) && periph_phase_o[3]) |=>
      (periph_phase_o == 4'h1) ##3 (periph_phase_o == 4'h8)
  ) else $error("peripheral phases stopped or skipped");

  // Phases keep toggling through idle cycles
  AST_PHASE_IDLE: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_q)
    (!cpu_exec_o && periph_phase_o != '0) |=>
      (periph_phase_o != $past(periph_phase_o) && periph_phase_o != '0)
  ) else $error("peripheral phases frozen in an idle cycle");

  // Oscillator request never drops
  AST_OSC_RUN: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_q)
    osc_run_o
  ) else $error("oscillator run request dropped");

  // CPU phases and fetch only in active cycles, matching peripherals
  AST_FETCH_ACTIVE: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_q)
    (cpu_phase_o != '0) |->
      (program_flash_fetch_o && cpu_phase_o == periph_phase_o)
  ) else $error("CPU phase without flash fetch or misaligned");

  // With doze off the next cycle is always active
  AST_NO_DOZE: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_q)
    (phase_last && !slow_exec_enable_i) |=> ##1 cpu_exec_o [*4]
  ) else $error("idle cycle inserted while doze is off");

  // Scenario coverage
  COV_RATIO_32: cover property (
    @(posedge core_clk_i) disable iff (!rst_n_q)
    phase_last && !active && cap_q == cdg_pkg::RATIO_1_32 && gap_q == 8'h1e
  );

  COV_RATIO_4: cover property (
    @(posedge core_clk_i) disable iff (!rst_n_q)
    phase_last && !active && cap_q == cdg_pkg::RATIO_1_4 && gap_q == 8'h02
  );

  COV_DISABLE_IN_IDLE: cover property (
    @(posedge core_clk_i) disable iff (!rst_n_q)
    phase_last && !active && !slow_exec_enable_i
  );

  COV_RATIO_CHANGE: cover property (
    @(posedge core_clk_i) disable iff (!rst_n_q)
    phase_last && !active && doze_ratio_i != cap_q
  );

endmodule : cdg_doze_gate
`default_nettype wire

// ### testbench/cdg_cpu_model.sv
// Behavioural CPU core and fetch path on the gated side of the block
`timescale 1ns/100ps
`default_nettype none
module cdg_cpu_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic exec_i,
  input wire logic fetch_i,
  input wire logic [cdg_pkg::QPH_W-1:0] phase_i,
  output logic [15:0] done_o,
  output logic bad_o
);
  // Retire one instruction at the last quarter of each granted cycle
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      done_o <= 16'h0000;
      bad_o <= 1'b0;
    end else if (phase_i == 4'h8) begin
      done_o <= done_o + 16'h0001;
      bad_o <= bad_o | !(exec_i && fetch_i);
    end
  end
endmodule : cdg_cpu_model
`default_nettype wire

// ### testbench/tb_cpu_doze_cycle_gating.sv
// Self-checking bench for the doze cycle gating block
`timescale 1ns/100ps
`default_nettype none
module tb_cpu_doze_cycle_gating;
  logic clk, rstn, en, exec, fetch, osc, bad;
  logic [2:0] ratio;
  logic [3:0] pph, cph, ph_prev;
  logic [15:0] done;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  bit ex_prev;

  cdg_doze_gate u_cdg_doze_gate (.core_clk_i(clk), .rstn_i(rstn),
    .slow_exec_enable_i(en), .doze_ratio_i(ratio), .periph_phase_o(pph),
    .cpu_phase_o(cph), .cpu_exec_o(exec), .program_flash_fetch_o(fetch),
    .osc_run_o(osc));
  cdg_cpu_model u_cdg_cpu_model (.clk_i(clk), .rstn_i(rstn), .exec_i(exec),
    .fetch_i(fetch), .phase_i(cph), .done_o(done), .bad_o(bad));

  // System clock, 20 ns period
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // Shared compare
  task automatic chk(input string what, input logic [15:0] exp,
      input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One clock with the per-cycle relations; flags a rise of exec
  task automatic step(output bit r);
    @(negedge clk);
    chk("periph", 16'({ph_prev[2:0], ph_prev[3]}), 16'(pph));
    chk("cpu_phase", exec ? 16'(pph) : 16'h0000, 16'(cph));
    chk("fetch", 16'(exec), 16'(fetch));
    chk("osc_run", 16'h0001, 16'(osc));
    r = exec && !ex_prev;
    ph_prev = pph;
    ex_prev = exec;
  endtask : step

  // Reset for 3 clocks, then sync to the first quarter
  task automatic do_reset();
    rstn = 1'b0;
    repeat (3) @(negedge clk);
    chk("exec_rst", 16'h0000, 16'(exec));
    chk("osc_rst", 16'h0001, 16'(osc));
    chk("ph_rst", 16'h0000, 16'(pph));
    rstn = 1'b1;
    for (int i = 0; i < 8 && pph !== 4'h1; i++) @(negedge clk);
    chk("exec_first", 16'h0001, 16'(exec));
    ph_prev = pph;
    ex_prev = exec;
  endtask : do_reset

  // Skip some active entries, then time one active-to-active span
  task automatic gap(input int waits, input int n);
    bit r;
    int hi;
    int len;
    logic [15:0] d0;
    repeat (waits) begin
      r = 1'b0;
      for (int i = 0; i < 1100 && !r; i++) step(r);
    end
    hi = 0;
    len = 0;
    d0 = done;
    r = 1'b0;
    while (!r && len < 1100) begin
      hi += int'(exec);
      len++;
      step(r);
    end
    chk("active_len", 16'h0004, 16'(hi));
    chk("period", 16'(4 * n), 16'(len));
    chk("retired", 16'h0001, done - d0);
  endtask : gap

  // Doze off: every cycle runs
  task automatic chk_disabled();
    bit r;
    en = 1'b0;
    repeat (16) begin
      step(r);
      chk("exec_off", 16'h0001, 16'(exec));
    end
  endtask : chk_disabled

  // Every ratio code
  task automatic chk_ratios();
    for (int c = 0; c < 8; c++) begin
      en = 1'b1;
      ratio = 3'(c);
      gap(2, 2 << c);
    end
  endtask : chk_ratios

  // Ratio change lands at the next active entry
  task automatic chk_change();
    ratio = cdg_pkg::RATIO_1_4;
    gap(2, 4);
    ratio = cdg_pkg::RATIO_1_32;
    gap(0, 4);
    gap(0, 32);
  endtask : chk_change

  // Dropping enable mid idle run resumes execution
  task automatic chk_abort();
    bit r;
    int i;
    repeat (12) step(r);
    en = 1'b0;
    for (i = 0; i < 12 && exec !== 1'b1; i++) step(r);
    chk("abort_wait", 16'h0001, 16'(i <= 8));
    chk_disabled();
  endtask : chk_abort

  // Verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // Main sequence
  initial begin
    rstn = 1'b0;
    en = 1'b0;
    ratio = 3'h0;
    ph_prev = 4'h0;
    ex_prev = 1'b0;
    do_reset();
    chk_disabled();
    chk_ratios();
    chk_change();
    chk_abort();
    chk("model_fault", 16'h0000, 16'(bad));
    en = 1'b1;
    do_reset();
    chk_disabled();
    chk("model_fault", 16'h0000, 16'(bad));
    tally_and_finish();
  end
endmodule : tb_cpu_doze_cycle_gating
`default_nettype wire
